// ### host_capture.sv
/* host model latching each valid word.
 assumes words settle after the rising edge. */
`timescale 1ns/1ns
`default_nettype none
module host_capture (
	// parallel word
	input wire clk,
	input wire [7:0] sampleWord,
	input wire wordValid,
	output logic [7:0] heldWord
);
	always @(posedge clk) begin
		if (wordValid)
			heldWord <= sampleWord;
	end
endmodule
`default_nettype wire

// ### sample_output_path.v
/*
 digital output path of an 8-bit pipelined sampling converter, with a
 16-word fifo between the pipeline and the output register.
 assumes an already quantised input word and above/below range flags
 from the analog front end, sampled on the falling edge of clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sample_path_defs.vh"

module sample_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// fill side
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	// drain side
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr_r;
	reg [AW-1:0] rdPtr_r;
	reg [AW:0] count_r;
	wire full;
	wire empty;
	wire doWr;
	wire doRd;

	// pointers wrap at the depth, which must be a power of two
	function [AW-1:0] nextPtr;
		input [AW-1:0] p;
		begin
			nextPtr = p + 1'b1;
		end
	endfunction

	function [AW:0] nextCount;
		input [AW:0] c;
		input wr;
		input rd;
		begin
			if (wr && !rd) begin
				nextCount = c + 1'b1;
			end else if (rd && !wr) begin
				nextCount = c - 1'b1;
			end else begin
				nextCount = c;
			end
		end
	endfunction

	assign full = (count_r == DEPTH[AW:0]);
	assign empty = (count_r == {(AW+1){1'b0}});
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[rdPtr_r];
	assign doWr = inValid && inReady;
	assign doRd = outValid && outReady;

	always @(posedge clk) begin
		if (doWr) begin
			mem[wrPtr_r] <= inData;
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			wrPtr_r <= {AW{1'b0}};
			rdPtr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (doWr) begin
				wrPtr_r <= nextPtr(wrPtr_r);
			end
			if (doRd) begin
				rdPtr_r <= nextPtr(rdPtr_r);
			end
			count_r <= nextCount(count_r, doWr, doRd);
		end
	end
endmodule

// Contract
// - capture the input word on every falling clock edge
// - output word changes only on a rising clock edge
// - result reaches output stage two and a half cycles after its sample
// - one new output word every clock cycle
// - eight-bit straight binary result between bottom and top reference
// - below range gives all zeros, above range all ones
// - sleep request high holds last word on outputs
// - converts continuously with no start command
module sample_output_path (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// front end
	input wire [`WORD_W-1:0] quantWord,
	input wire belowRange,
	input wire aboveRange,
	// control
	input wire sleep_request_pin,
	// parallel output
	output reg [`WORD_W-1:0] sampleWord,
	output reg wordValid,
	output wire fifoReady
);
	localparam ST_RUN = 1'b0;
	localparam ST_SLEEP = 1'b1;

	reg state_r;
	reg state_nxt;
	reg [`WORD_W-1:0] sampled_r;
	reg [`WORD_W-1:0] stage1_r;
	reg stage1Valid_r;
	reg sampledValid_r;
	wire running;
	wire fifoInValid;
	wire fifoOutValid;
	wire [`WORD_W-1:0] fifoOut;
	wire drain;

	function [`WORD_W-1:0] clampCode;
		input [`WORD_W-1:0] w;
		input lo;
		input hi;
		begin
			if (lo) begin
				clampCode = `CODE_ZERO;
			end else if (hi) begin
				clampCode = `CODE_FULL;
			end else begin
				clampCode = w;
			end
		end
	endfunction

	// falling-edge capture; no reset so sampling never stalls
	always @(negedge clk) begin
		sampled_r <= clampCode(quantWord, belowRange, aboveRange);
		sampledValid_r <= rst_n;
	end

	// sample half a cycle before stage1; fifo write and output register
	// bring the word to the pins 2.5 cycles after its falling edge
	always @(posedge clk) begin
		if (!rst_n) begin
			stage1_r <= `CODE_ZERO;
			stage1Valid_r <= 1'b0;
		end else begin
			stage1_r <= sampled_r;
			stage1Valid_r <= sampledValid_r;
		end
	end

	// words arriving in sleep are dropped, not queued
	assign fifoInValid = stage1Valid_r && running;

	sample_fifo #(
		.WIDTH(`WORD_W),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.inValid(fifoInValid),
		.inReady(fifoReady),
		.inData(stage1_r),
		.outValid(fifoOutValid),
		.outReady(drain),
		.outData(fifoOut)
	);

	// draining stalls in sleep; the one queued word leaves first on wake
	assign drain = running;

	assign running = (state_r == ST_RUN);

	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_RUN: begin
			if (sleep_request_pin) begin
				state_nxt = ST_SLEEP;
			end
		end
		ST_SLEEP: begin
			if (!sleep_request_pin) begin
				state_nxt = ST_RUN;
			end
		end
		default: begin
			state_nxt = ST_RUN;
		end
		endcase
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			state_r <= ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// output register updates on rising edges only, one word per cycle
	always @(posedge clk) begin
		if (!rst_n) begin
			sampleWord <= `CODE_ZERO;
			wordValid <= 1'b0;
		end else if (running && fifoOutValid) begin
			sampleWord <= fifoOut;
			wordValid <= 1'b1;
		end else if (!running) begin
			wordValid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### sample_output_path_checker.sv
/* port checker for the sample output path.
 assumes one clk domain and the bind below. */
`timescale 1ns/1ns
`default_nettype none
module sample_output_path_checker (
	// watched ports
	input wire clk,
	input wire rst_n,
	input wire [7:0] quantWord,
	input wire belowRange,
	input wire aboveRange,
	input wire sleep_request_pin,
	input wire [7:0] sampleWord,
	input wire wordValid,
	input wire fifoReady
);
	wire [7:0] c = belowRange ? 8'h00 : aboveRange ? 8'hff : quantWord;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// pipeline full only once reset is long gone
	sequence s_run; (!sleep_request_pin && $past(rst_n, 5))[*8]; endsequence
	property p_lat; s_run |-> sampleWord == $past(c, 3); endproperty
	a_lat: assert property (p_lat) else $error("lag");
	property p_lo; s_run ##0 $past(belowRange, 3) |-> !sampleWord; endproperty
	a_lo: assert property (p_lo) else $error("low");
	property p_hi; s_run ##0 $past(c, 3) == 8'hff |-> &sampleWord; endproperty
	a_hi: assert property (p_hi) else $error("high");
	property p_new; s_run ##0 $past(c, 3) != $past(c, 4)
		|-> $changed(sampleWord); endproperty
	a_new: assert property (p_new) else $error("stuck");
	property p_val; s_run |-> wordValid; endproperty
	a_val: assert property (p_val) else $error("gap");
	property p_rdy; s_run |-> fifoReady; endproperty
	a_rdy: assert property (p_rdy) else $error("full");
	property p_hold; sleep_request_pin[*3] |-> $stable(sampleWord); endproperty
	a_hold: assert property (p_hold) else $error("moved");
	property p_off; sleep_request_pin[*3] |-> !wordValid; endproperty
	a_off: assert property (p_off) else $error("valid");
	cover property (s_run);
	cover property (sleep_request_pin[*3]);
	cover property (belowRange && aboveRange);
endmodule
bind sample_output_path sample_output_path_checker u_chk (.*);
`default_nettype wire

// ### sample_output_path_test.sv
/* random words through the path, then sleep and a second reset.
 assumes the checker and host model compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests = n_tests + 1; if ((a) !== (b)) begin \
	errors = errors + 1; $display("Error %0t: word", $time); end end
module sample_output_path_test;
	reg clk = 0, rst_n = 0, belowRange = 0, aboveRange = 0, sl = 0;
	reg [7:0] quantWord = 8'h00, w0;
	reg [7:0] h [0:4];
	wire [7:0] sampleWord, heldWord;
	wire wordValid, fifoReady;
	integer seed = 32'hd400, errors = 0, n_tests = 0, cyc = 0, i, j, k;
	always #5 clk = ~clk;
	sample_output_path u_dut (.clk(clk), .rst_n(rst_n), .quantWord(quantWord),
		.belowRange(belowRange), .aboveRange(aboveRange),
		.sleep_request_pin(sl), .sampleWord(sampleWord),
		.wordValid(wordValid), .fifoReady(fifoReady));
	host_capture u_host (.clk(clk), .sampleWord(sampleWord),
		.wordValid(wordValid), .heldWord(heldWord));
	task tally_and_finish;
		if (errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task step(input [7:0] w, input lo, input hi, input s, input chk);
		@(posedge clk);
		#1;
		if (chk) `CHK(heldWord, h[3])
		for (j = 4; j > 0; j = j - 1)
			h[j] = h[j-1];
		h[0] = lo ? 8'h00 : hi ? 8'hff : w;
		{quantWord, belowRange, aboveRange, sl} = {w, lo, hi, s};
	endtask
	task run(input integer n);
		for (i = 0; i < n; i = i + 1) begin
			k = $random(seed);
			step(i < 9 ? 8'hff : k[7:0], k[10:8] == 0, k[13:11] == 0, 0, i > 9);
		end
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			errors = errors + 1;
			tally_and_finish;
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		#1 rst_n = 1;
		run(400);
		step(8'h5a, 0, 0, 1, 0);
		step(8'h00, 0, 0, 1, 0);
		w0 = h[3];
		for (k = 0; k < 6; k = k + 1) begin
			step(8'h33, 0, 0, 1, 0);
			`CHK(sampleWord, w0)
			`CHK(wordValid, 1'b0)
			`CHK(heldWord, w0)
		end
		run(20);
		rst_n = 0;
		step(8'h00, 0, 0, 0, 0);
		step(8'h00, 0, 0, 0, 0);
		rst_n = 1;
		run(40);
		tally_and_finish;
	end
endmodule
`default_nettype wire

// ### sample_path_defs.vh
/*
 constants for the pipelined sample output path.
 assumes inclusion by bare name from the design file.
*/
`ifndef SAMPLE_PATH_DEFS_VH
`define SAMPLE_PATH_DEFS_VH
`define WORD_W 8
`define CODE_ZERO 8'h00
`define CODE_FULL 8'hff
`define CLK_PERIOD_NS 10
`define APERTURE_DELAY_TENTHS_NS 15
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define PIPE_HALF_CYCLES 5
`endif
